// [rtl/sau_arith_unit.sv]
// Function
// RQ1 - Vectored-mode set (ED prefix) enters mode 2; peripheral byte is pointer low.
// RQ2 - Vector base register supplies pointer high byte; entry fetched is routine start.
// RQ3 - Vectored-mode set takes 2 machine cycles, 8 states, flags unchanged.
// RQ4 - Pair add sums selected pair into pointer pair; 3 cycles, 11 states.
// RQ5 - Select 00 counter pair, 01 second pair, 10 pointer pair, 11 stack.
// RQ6 - Plain adds: half from bit 11, carry from bit 15, N cleared.
// RQ7 - Add with carry (ED) adds pair and carry into pointer; 4 cycles, 15.
// RQ8 - Add with carry sets sign, zero, half, overflow, clears N, sets carry.
// RQ9 - Subtract with borrow (ED) subtracts pair and carry; 4 cycles, 15 states.
// RQ10 - Subtract sets sign, zero, borrow bit 12, overflow, N set, borrow carry.
// RQ11 - DD add sums pair into first index; code 10 is that index; 4/15.
// RQ12 - FD add sums pair into second index; code 10 is itself; plain flags.
// RQ13 - Pair increment adds one to selected pair; flags unchanged.
// RQ14 - DD 23 increments first index; 2 cycles, 4 and 6 states; flags kept.
// RQ15 - FD 23 increments second index; flags unchanged.
// RQ16 - Pair decrement subtracts one in one cycle of 6 states; flags kept.
// RQ17 - DD 2B decrements first index.
// RQ18 - FD 2B decrements second index; 2 cycles, 10 states; flags unchanged.
// RQ19 - All 16-bit arithmetic wraps modulo 65536; only flagged ops touch flags.
`timescale 1ns/1ps
`include "sau_defines.svh"

module sau_arith_unit (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Vectored interrupt pointer and status
  output logic      [15:0] vectorPointer,
  output logic             busy
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [15:0]         counterPair, secondPair, pointerPair, stackPointer;
  logic [15:0]         firstIndex, secondIndex;
  logic [15:0]         next_counterPair, next_secondPair, next_pointerPair;
  logic [15:0]         next_stackPointer, next_firstIndex, next_secondIndex;
  logic [7:0]          flags, next_flags, vectorBase, next_vectorBase;
  logic [7:0]          periphVector, next_periphVector;
  logic [1:0]          intMode, next_intMode;
  logic [15:0]         opcode, next_opcode;
  logic [7:0]          stateCount, next_stateCount, lastStates, next_lastStates;
  logic [3:0]          lastMachine, next_lastMachine;
  logic                badOpcode, next_badOpcode;
  sau_pkg::sau_state_t state, next_state;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Pair select decode shared by plain and index forms; idx replaces code 10.
  function automatic logic [15:0] pick_pair(input logic [1:0] sel, input logic [15:0] b,
      input logic [15:0] d, input logic [15:0] self, input logic [15:0] sp);
    case (sel)
      2'b00:   pick_pair = b;     // [RQ5]
      2'b01:   pick_pair = d;
      2'b10:   pick_pair = self;
      default: pick_pair = sp;
    endcase
  endfunction : pick_pair

  logic [7:0]       pfx, op;
  logic [1:0]       sel;
  logic             isEd, isDd, isFd, noPfx;
  sau_pkg::sau_op_t kind;
  logic [7:0]       tStates;
  logic [3:0]       mCycles;
  logic [15:0]      dstVal, srcVal;
  logic [1:0]       dstSel;         // 0 pointer pair, 1 first index, 2 second index, 3 pair
  logic [16:0]      sum;
  logic [12:0]      low12;
  logic             carryIn;

  assign pfx = opcode[15:8];
  assign op  = opcode[7:0];
  assign sel = op[`SAU_SEL_HI:`SAU_SEL_LO];
  assign isEd  = (pfx == `SAU_PFX_ED);
  assign isDd  = (pfx == `SAU_PFX_DD);
  assign isFd  = (pfx == `SAU_PFX_FD);
  assign noPfx = (pfx == 8'h00);
  assign carryIn = flags[`SAU_F_CARRY];

  // Classify the opcode and pick its timing and operands.
  always_comb begin
    kind    = sau_pkg::OP_BAD;
    tStates = 8'd1;
    mCycles = 4'd0;
    dstSel  = 2'd0;
    srcVal  = pick_pair(sel, counterPair, secondPair, pointerPair, stackPointer);
    dstVal  = pointerPair;
    if (isEd && op == `SAU_OP_MODE2) begin
      kind = sau_pkg::OP_MODE2; tStates = `SAU_T_MODE2; mCycles = `SAU_M_MODE2; // [RQ3]
    end else if (isEd && op[7:6] == 2'b01 && op[3:0] == 4'ha) begin
      kind = sau_pkg::OP_ADC; tStates = `SAU_T_LONG; mCycles = `SAU_M_LONG; // [RQ7]
    end else if (isEd && op[7:6] == 2'b01 && op[3:0] == 4'h2) begin
      kind = sau_pkg::OP_SBC; tStates = `SAU_T_LONG; mCycles = `SAU_M_LONG; // [RQ9]
    end else if ((isDd || isFd) && op == `SAU_OP_INCIDX) begin
      kind = sau_pkg::OP_INC; tStates = `SAU_T_IDXSTEP; mCycles = `SAU_M_IDXSTEP; // [RQ14]
      dstSel = isDd ? 2'd1 : 2'd2;                                  // [RQ15]
    end else if ((isDd || isFd) && op == `SAU_OP_DECIDX) begin
      kind = sau_pkg::OP_DEC; tStates = `SAU_T_IDXSTEP; mCycles = `SAU_M_IDXSTEP; // [RQ17]
      dstSel = isDd ? 2'd1 : 2'd2;                                  // [RQ18]
    end else if ((isDd || isFd) && op[7:6] == 2'b00 && op[3:0] == 4'h9) begin
      kind = sau_pkg::OP_ADD; tStates = `SAU_T_LONG; mCycles = `SAU_M_LONG; // [RQ11]
      dstSel = isDd ? 2'd1 : 2'd2;                                  // [RQ12]
      srcVal = isDd ? pick_pair(sel, counterPair, secondPair, firstIndex, stackPointer)
                    : pick_pair(sel, counterPair, secondPair, secondIndex, stackPointer);
    end else if (noPfx && op[7:6] == 2'b00 && op[3:0] == 4'h9) begin
      kind = sau_pkg::OP_ADD; tStates = `SAU_T_ADD; mCycles = `SAU_M_ADD; // [RQ4]
    end else if (noPfx && op[7:6] == 2'b00 && op[3:0] == 4'h3) begin
      kind = sau_pkg::OP_INC; tStates = `SAU_T_INC; mCycles = `SAU_M_INC; // [RQ13]
      dstSel = 2'd3;
    end else if (noPfx && op[7:6] == 2'b00 && op[3:0] == 4'hb) begin
      kind = sau_pkg::OP_DEC; tStates = `SAU_T_INC; mCycles = `SAU_M_INC; // [RQ16]
      dstSel = 2'd3;
    end
    case (dstSel)
      2'd1:    dstVal = firstIndex;
      2'd2:    dstVal = secondIndex;
      2'd3:    dstVal = srcVal;
      default: dstVal = pointerPair;
    endcase
  end

  // --------------------------------------------------------------------------
  // Arithmetic: 17-bit sum keeps the carry; the 16-bit result wraps freely.
  // --------------------------------------------------------------------------
  logic [15:0] result;
  logic [15:0] operandB;
  logic        cin;
  always_comb begin
    operandB = srcVal;
    cin      = 1'b0;
    case (kind)
      sau_pkg::OP_ADC: cin = carryIn;
      sau_pkg::OP_SBC: begin
        operandB = ~srcVal;          // Subtract as add of complement.
        cin      = ~carryIn;
      end
      sau_pkg::OP_INC: begin
        operandB = 16'h0000;
        cin      = 1'b1;
      end
      sau_pkg::OP_DEC: operandB = 16'hffff;
      default: ;
    endcase
  end
  assign sum    = {1'b0, dstVal} + {1'b0, operandB} + {16'h0000, cin};   // [RQ19]
  assign low12  = {1'b0, dstVal[11:0]} + {1'b0, operandB[11:0]} + {12'h000, cin};
  assign result = sum[15:0];

  // Flag byte after the instruction.
  logic [7:0] newFlags;
  logic       ovf;
  assign ovf = (dstVal[15] == operandB[15]) && (result[15] != dstVal[15]);
  always_comb begin
    newFlags = flags;              // Untouched unless the op defines flags. [RQ19]
    case (kind)
      sau_pkg::OP_ADD: begin
        newFlags[`SAU_F_HALF]  = low12[12];                        // [RQ6]
        newFlags[`SAU_F_SUB]   = 1'b0;
        newFlags[`SAU_F_CARRY] = sum[16];
      end
      sau_pkg::OP_ADC: begin
        newFlags[`SAU_F_SIGN]  = result[15];                       // [RQ8]
        newFlags[`SAU_F_ZERO]  = (result == 16'h0000);
        newFlags[`SAU_F_HALF]  = low12[12];
        newFlags[`SAU_F_PV]    = ovf;
        newFlags[`SAU_F_SUB]   = 1'b0;
        newFlags[`SAU_F_CARRY] = sum[16];
      end
      sau_pkg::OP_SBC: begin
        newFlags[`SAU_F_SIGN]  = result[15];                       // [RQ10]
        newFlags[`SAU_F_ZERO]  = (result == 16'h0000);
        newFlags[`SAU_F_HALF]  = ~low12[12];
        newFlags[`SAU_F_PV]    = ovf;
        newFlags[`SAU_F_SUB]   = 1'b1;
        newFlags[`SAU_F_CARRY] = ~sum[16];
      end
      default: ;                   // Mode set, inc and dec keep flags. [RQ3] [RQ13] [RQ16]
    endcase
  end

  // --------------------------------------------------------------------------
  // APB decode: zero wait states, pready is always high.
  // --------------------------------------------------------------------------
  logic wrEn, rdEn, mapped, start;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `SAU_OFS_INTMODE);
  // A start write while busy is dropped; software polls the busy bit.
  assign start = wrEn && (paddr == `SAU_OFS_CTRL) && pwdata[0] && state == sau_pkg::ST_IDLE;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Next-state logic for registers, execution counter and cycle report.
  always_comb begin
    next_counterPair = counterPair;  next_secondPair   = secondPair;
    next_pointerPair = pointerPair;  next_stackPointer = stackPointer;
    next_firstIndex  = firstIndex;   next_secondIndex  = secondIndex;
    next_flags = flags;  next_vectorBase = vectorBase;  next_periphVector = periphVector;
    next_intMode = intMode;  next_opcode = opcode;  next_state = state;
    next_stateCount = stateCount;  next_lastStates = lastStates;
    next_lastMachine = lastMachine;  next_badOpcode = badOpcode;
    if (wrEn && state == sau_pkg::ST_IDLE) begin
      case (paddr)
        `SAU_OFS_OPCODE:   next_opcode       = pwdata[15:0];
        `SAU_OFS_FLAGS:    next_flags        = pwdata[7:0];
        `SAU_OFS_COUNTER:  next_counterPair  = pwdata[15:0];
        `SAU_OFS_SECOND:   next_secondPair   = pwdata[15:0];
        `SAU_OFS_POINTER:  next_pointerPair  = pwdata[15:0];
        `SAU_OFS_STACK:    next_stackPointer = pwdata[15:0];
        `SAU_OFS_FIRSTIX:  next_firstIndex   = pwdata[15:0];
        `SAU_OFS_SECONDIX: next_secondIndex  = pwdata[15:0];
        `SAU_OFS_VECBASE:  next_vectorBase   = pwdata[7:0];
        `SAU_OFS_VECTOR:   next_periphVector = pwdata[7:0];
        default: ;
      endcase
    end
    case (state)
      sau_pkg::ST_IDLE: begin
        if (start) begin
          next_state      = sau_pkg::ST_BUSY;
          next_stateCount = tStates;
          next_badOpcode  = (kind == sau_pkg::OP_BAD);
        end
      end
      sau_pkg::ST_BUSY: begin
        next_stateCount = stateCount - 8'd1;
        if (stateCount == 8'd1) begin
          // Commit on the last clock state so the cycle count is exact.
          next_state       = sau_pkg::ST_IDLE;
          next_lastStates  = tStates;
          next_lastMachine = mCycles;
          next_flags       = newFlags;
          if (kind == sau_pkg::OP_MODE2) next_intMode = 2'd2;     // [RQ1]
          if (kind != sau_pkg::OP_MODE2 && kind != sau_pkg::OP_BAD) begin
            case (dstSel)
              2'd1: next_firstIndex  = result;                     // [RQ11] [RQ14] [RQ17]
              2'd2: next_secondIndex = result;                     // [RQ12] [RQ15] [RQ18]
              2'd3: begin
                case (sel)                                         // [RQ5] [RQ13] [RQ16]
                  2'b00:   next_counterPair  = result;
                  2'b01:   next_secondPair   = result;
                  2'b10:   next_pointerPair  = result;
                  default: next_stackPointer = result;
                endcase
              end
              default: next_pointerPair = result;                  // [RQ4] [RQ7] [RQ9]
            endcase
          end
        end
      end
      default: next_state = sau_pkg::ST_IDLE;
    endcase
  end

  // Register all state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      counterPair <= 16'h0000; secondPair <= 16'h0000; pointerPair <= 16'h0000;
      stackPointer <= 16'h0000; firstIndex <= 16'h0000; secondIndex <= 16'h0000;
      flags <= 8'h00; vectorBase <= 8'h00; periphVector <= 8'h00; intMode <= 2'd0;
      opcode <= 16'h0000; state <= sau_pkg::ST_IDLE; stateCount <= 8'h00;
      lastStates <= 8'h00; lastMachine <= 4'h0; badOpcode <= 1'b0;
    end else begin
      counterPair <= next_counterPair; secondPair <= next_secondPair;
      pointerPair <= next_pointerPair; stackPointer <= next_stackPointer;
      firstIndex <= next_firstIndex; secondIndex <= next_secondIndex;
      flags <= next_flags; vectorBase <= next_vectorBase;
      periphVector <= next_periphVector; intMode <= next_intMode;
      opcode <= next_opcode; state <= next_state; stateCount <= next_stateCount;
      lastStates <= next_lastStates; lastMachine <= next_lastMachine;
      badOpcode <= next_badOpcode;
    end
  end

  // Read mux (combinational) and vector pointer output (registered).
  logic [31:0] next_prdata;
  logic [15:0] next_vectorPointer;
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `SAU_OFS_OPCODE:   next_prdata = {16'h0000, opcode};
      `SAU_OFS_STATUS:   next_prdata = {29'h0, badOpcode, intMode == 2'd2, state == sau_pkg::ST_BUSY};
      `SAU_OFS_FLAGS:    next_prdata = {24'h0, flags};
      `SAU_OFS_COUNTER:  next_prdata = {16'h0000, counterPair};
      `SAU_OFS_SECOND:   next_prdata = {16'h0000, secondPair};
      `SAU_OFS_POINTER:  next_prdata = {16'h0000, pointerPair};
      `SAU_OFS_STACK:    next_prdata = {16'h0000, stackPointer};
      `SAU_OFS_FIRSTIX:  next_prdata = {16'h0000, firstIndex};
      `SAU_OFS_SECONDIX: next_prdata = {16'h0000, secondIndex};
      `SAU_OFS_VECBASE:  next_prdata = {24'h0, vectorBase};
      `SAU_OFS_VECTOR:   next_prdata = {24'h0, periphVector};
      `SAU_OFS_CYCLES:   next_prdata = {20'h0, lastMachine, lastStates};
      `SAU_OFS_INTMODE:  next_prdata = {30'h0, intMode};
      default: ;
    endcase
    next_vectorPointer = {vectorBase, periphVector};                 // [RQ2] [RQ1]
  end
  // Read data is a plain mux of the register set, so zero-wait reads need no extra cycle.
  assign prdata = rdEn ? next_prdata : 32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vectorPointer <= 16'h0000;
      busy          <= 1'b0;
    end else begin
      vectorPointer <= next_vectorPointer;
      busy          <= (next_state == sau_pkg::ST_BUSY);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_add_states: assert property (@(posedge sys_clk) disable iff (reset) // [RQ4]
    start && kind == sau_pkg::OP_ADD && noPfx |=> busy [*8] ##1 busy [*3] ##1 !busy)
    else $error("pair add did not take 11 states");
  a_long_states: assert property (@(posedge sys_clk) disable iff (reset) // [RQ7]
    start && (kind == sau_pkg::OP_ADC || kind == sau_pkg::OP_SBC)
    |=> busy [*8] ##1 busy [*7] ##1 !busy)
    else $error("long op did not take 15 states");
  a_mode_flags: assert property (@(posedge sys_clk) disable iff (reset) // [RQ3]
    state == sau_pkg::ST_BUSY && stateCount == 8'd1 && kind == sau_pkg::OP_MODE2
    |=> flags == $past(flags) && intMode == 2'd2)
    else $error("mode set changed flags or missed mode");
  a_inc_flags: assert property (@(posedge sys_clk) disable iff (reset) // [RQ13]
    state == sau_pkg::ST_BUSY && stateCount == 8'd1 &&
    (kind == sau_pkg::OP_INC || kind == sau_pkg::OP_DEC) |=> flags == $past(flags))
    else $error("step op changed flags");
  a_sub_nflag: assert property (@(posedge sys_clk) disable iff (reset) // [RQ10]
    state == sau_pkg::ST_BUSY && stateCount == 8'd1 && kind == sau_pkg::OP_SBC
    |=> flags[`SAU_F_SUB] && pointerPair == $past(result))
    else $error("subtract result or N flag wrong");
  a_add_keep: assert property (@(posedge sys_clk) disable iff (reset) // [RQ6]
    state == sau_pkg::ST_BUSY && stateCount == 8'd1 && kind == sau_pkg::OP_ADD
    |=> !flags[`SAU_F_SUB] && flags[`SAU_F_ZERO] == $past(flags[`SAU_F_ZERO]))
    else $error("plain add flags wrong");
  a_dec_states: assert property (@(posedge sys_clk) disable iff (reset) // [RQ16]
    start && kind == sau_pkg::OP_DEC && noPfx |=> busy [*6] ##1 !busy)
    else $error("pair decrement did not take 6 states");
  a_vec_pointer: assert property (@(posedge sys_clk) disable iff (reset) // [RQ2]
    ##1 vectorPointer == {$past(vectorBase), $past(periphVector)})
    else $error("vector pointer not base and vector");

endmodule : sau_arith_unit

// [rtl/sau_defines.svh]
`ifndef SAU_DEFINES_SVH
`define SAU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map, byte addresses on the APB word grid
// ----------------------------------------------------------------------------
`define SAU_OFS_CTRL      12'h000
`define SAU_OFS_OPCODE    12'h004
`define SAU_OFS_STATUS    12'h008
`define SAU_OFS_FLAGS     12'h00c
`define SAU_OFS_COUNTER   12'h010
`define SAU_OFS_SECOND    12'h014
`define SAU_OFS_POINTER   12'h018
`define SAU_OFS_STACK     12'h01c
`define SAU_OFS_FIRSTIX   12'h020
`define SAU_OFS_SECONDIX  12'h024
`define SAU_OFS_VECBASE   12'h028
`define SAU_OFS_VECTOR    12'h02c
`define SAU_OFS_CYCLES    12'h030
`define SAU_OFS_INTMODE   12'h034

// ----------------------------------------------------------------------------
// Opcode bytes and field positions
// ----------------------------------------------------------------------------
`define SAU_PFX_ED        8'hed
`define SAU_PFX_DD        8'hdd
`define SAU_PFX_FD        8'hfd
`define SAU_OP_MODE2      8'h56
`define SAU_OP_INCIDX     8'h23
`define SAU_OP_DECIDX     8'h2b
`define SAU_SEL_HI        5
`define SAU_SEL_LO        4

// ----------------------------------------------------------------------------
// Flag bit positions within the flag byte
// ----------------------------------------------------------------------------
`define SAU_F_CARRY       0
`define SAU_F_SUB         1
`define SAU_F_PV          2
`define SAU_F_HALF        4
`define SAU_F_ZERO        6
`define SAU_F_SIGN        7

// ----------------------------------------------------------------------------
// Timing: machine cycles and clock states per instruction
// ----------------------------------------------------------------------------
`define SAU_T_MODE2       8'd8
`define SAU_M_MODE2       4'd2
`define SAU_T_ADD         8'd11
`define SAU_M_ADD         4'd3
`define SAU_T_LONG        8'd15
`define SAU_M_LONG        4'd4
`define SAU_T_INC         8'd6
`define SAU_M_INC         4'd1
`define SAU_T_IDXSTEP     8'd10
`define SAU_M_IDXSTEP     4'd2

`endif

// [rtl/sau_pkg.sv]
package sau_pkg;

  // Operation executed by the datapath.
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_MODE2  = 4'h1,
    OP_ADD    = 4'h2,
    OP_ADC    = 4'h3,
    OP_SBC    = 4'h4,
    OP_INC    = 4'h5,
    OP_DEC    = 4'h6,
    OP_BAD    = 4'h7
  } sau_op_t;

  // Execution state: idle, or counting clock states of a running instruction.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } sau_state_t;

endpackage : sau_pkg

// [sim/test_sixteen_bit_arith_unit.sv]
`timescale 1ns/1ps
`include "sau_defines.svh"

module test_sixteen_bit_arith_unit;

  // ---------------------------------------------------------------------------
  // Stimulus signals and bookkeeping
  // ---------------------------------------------------------------------------
  logic        sysClk  = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] vectorPointer;
  logic        busy;
  int          nMismatch = 0;
  int          testsRun  = 0;
  int          cyc       = 0;

  always #4 sysClk = ~sysClk;

  sau_arith_unit i_sau_arith_unit (
    .sys_clk(sysClk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vectorPointer(vectorPointer), .busy(busy));

  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge sysClk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    @(posedge sysClk);
    while (pready !== 1'b1) @(posedge sysClk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask : rdChk

  // Counts busy cycles; the bound keeps a stuck busy from hanging the run.
  task automatic waitIdle(output int n);
    n = 0;
    for (int k = 0; k < 300; k++) begin
      @(posedge sysClk);
      if (busy !== 1'b1) break;
      n++;
    end
  endtask : waitIdle

  task automatic run(input logic [15:0] opw, input int states);
    int n;
    wr(`SAU_OFS_OPCODE, {16'h0, opw});
    wr(`SAU_OFS_CTRL, 32'h1);
    waitIdle(n);
    chk("busy states", states, n);
  endtask : run

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_add;
    wr(`SAU_OFS_FLAGS, 32'hc6);
    wr(`SAU_OFS_POINTER, 32'h8800);
    run(16'h0029, 11);
    rdChk(`SAU_OFS_CYCLES, 32'h30b, "cycles");
    rdChk(`SAU_OFS_POINTER, 32'h1000, "pointer");
    rdChk(`SAU_OFS_FLAGS, 32'hd5, "flags");
  endtask : t_add

  task automatic t_carry;
    wr(`SAU_OFS_FLAGS, 32'h01);
    wr(`SAU_OFS_POINTER, 32'hffff);
    wr(`SAU_OFS_COUNTER, 32'h0);
    run(16'hed4a, 15);
    rdChk(`SAU_OFS_CYCLES, 32'h40f, "cycles");
    rdChk(`SAU_OFS_POINTER, 32'h0, "pointer");
    rdChk(`SAU_OFS_FLAGS, 32'h51, "flags");
    wr(`SAU_OFS_FLAGS, 32'h00);
    wr(`SAU_OFS_POINTER, 32'h8000);
    wr(`SAU_OFS_STACK, 32'h1);
    run(16'hed72, 15);
    rdChk(`SAU_OFS_POINTER, 32'h7fff, "pointer");
    rdChk(`SAU_OFS_FLAGS, 32'h16, "flags");
  endtask : t_carry

  task automatic t_index;
    wr(`SAU_OFS_FLAGS, 32'hc6);
    wr(`SAU_OFS_FIRSTIX, 32'h4000);
    run(16'hdd29, 15);
    rdChk(`SAU_OFS_FIRSTIX, 32'h8000, "first index");
    rdChk(`SAU_OFS_FLAGS, 32'hc4, "flags");
    wr(`SAU_OFS_SECONDIX, 32'hf000);
    wr(`SAU_OFS_STACK, 32'h1000);
    run(16'hfd39, 15);
    rdChk(`SAU_OFS_SECONDIX, 32'h0, "second index");
    rdChk(`SAU_OFS_FLAGS, 32'hc5, "flags");
  endtask : t_index

  // Every step form, each across a wrap or plain count, with all flags preset.
  task automatic t_step;
    logic [15:0] ops[6]  = '{16'h0033, 16'h001b, 16'hdd23, 16'hfd23, 16'hdd2b, 16'hfd2b};
    logic [11:0] regs[6] = '{`SAU_OFS_STACK, `SAU_OFS_SECOND, `SAU_OFS_FIRSTIX,
                             `SAU_OFS_SECONDIX, `SAU_OFS_FIRSTIX, `SAU_OFS_SECONDIX};
    logic [15:0] pre[6]  = '{16'hffff, 16'h0000, 16'h3300, 16'hffff, 16'h0000, 16'h7649};
    logic [15:0] post[6] = '{16'h0000, 16'hffff, 16'h3301, 16'h0000, 16'hffff, 16'h7648};
    int          st[6]   = '{6, 6, 10, 10, 10, 10};
    wr(`SAU_OFS_FLAGS, 32'hd7);
    for (int i = 0; i < 6; i++) begin
      wr(regs[i], {16'h0, pre[i]});
      run(ops[i], st[i]);
      rdChk(regs[i], {16'h0, post[i]}, "stepped pair");
    end
    rdChk(`SAU_OFS_CYCLES, 32'h20a, "cycles");
    rdChk(`SAU_OFS_FLAGS, 32'hd7, "flags");
  endtask : t_step

  task automatic t_mode;
    wr(`SAU_OFS_VECBASE, 32'h12);
    wr(`SAU_OFS_VECTOR, 32'h34);
    run(16'hed56, 8);
    chk("vector pointer", 32'h1234, {16'h0, vectorPointer});
    rdChk(`SAU_OFS_STATUS, 32'h2, "status");
    rdChk(`SAU_OFS_CYCLES, 32'h208, "cycles");
    rdChk(`SAU_OFS_FLAGS, 32'hd7, "flags");
  endtask : t_mode

  // A write landing while busy must be dropped; odd codes and addresses refused.
  task automatic t_refuse;
    logic [31:0] r;
    logic        e;
    int          n;
    wr(`SAU_OFS_COUNTER, 32'h1111);
    wr(`SAU_OFS_POINTER, 32'h0010);
    wr(`SAU_OFS_OPCODE, 32'h0023);
    wr(`SAU_OFS_CTRL, 32'h1);
    wr(`SAU_OFS_COUNTER, 32'h5555);
    waitIdle(n);
    rdChk(`SAU_OFS_COUNTER, 32'h1111, "counter pair");
    rdChk(`SAU_OFS_POINTER, 32'h0011, "pointer");
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    run(16'hed00, 1);
    rdChk(`SAU_OFS_STATUS, 32'h6, "status");
    rdChk(`SAU_OFS_FLAGS, 32'hd7, "flags");
  endtask : t_refuse

  // ---------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------------------
  task automatic results;
    $display("mismatches %0d comparisons %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      nMismatch++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge sysClk);
    reset <= 1'b0;
    rdChk(`SAU_OFS_FLAGS, 32'h0, "flags after reset");
    chk("vector pointer after reset", 32'h0, {16'h0, vectorPointer});
    t_add();
    t_carry();
    t_index();
    t_step();
    t_mode();
    t_refuse();
    results();
  end

endmodule : test_sixteen_bit_arith_unit
